// ---- rtl/cbf_top.sv ----
// Channel block framer: frames user serial data into link blocks and
// turns received link blocks back into user serial data and clock.
// Assumes transport and configuration on core_clk_in, user input on
// user_clk_in, and configuration held steady while the channel runs.
//
// Summary of operation
// - Unblocked input framed into built 4800-bit blocks
// - Unblocked output delivers data field bits only
// - Rate set by digits and decimal exponent
// - Blocked output timed by external or internal clock
// - Unmodified header passes blocks bit for bit
// - Modified header inserts stream id, sequence, check
// - Time tag captured at sync pattern end
// - Check code regenerated over written time field
// - Untagged time passes, or static site pattern
// - Timeout pads, closes and sends the block
// - Timeout closes only on byte boundaries
// - Without timeout, accumulate; assurance blocks each second
// - Idle source sends one assurance block per second
// - Assurance block: zero length, 11001001 fill
// - Assurance option only forwards them to user
// - Free clock runs whenever channel enabled
// - Clamped clock held high while buffers empty
// - Unblocked output clock tracks input within 0.12 percent
// - Smooth mode waits five blocks or 264 ms
// - Datagram bit skips the smooth delay
// - 80-bit link header added and removed
`timescale 1ns/1ns
module cbf_top
    import cbf_pkg::*;
#(
    parameter int SEC_CYC = ONE_SEC_CYC,
    parameter int SMOOTH_CYC = SMOOTH_DLY_CYC
)
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic user_clk_in,
    input wire logic user_data_in,
    input wire logic user_frame_in,
    input wire logic cfg_chan_en_in,
    input wire logic cfg_blocked_in,
    input wire logic cfg_mod_hdr_in,
    input wire logic cfg_time_tag_in,
    input wire logic cfg_static_time_in,
    input wire logic cfg_timeout_in,
    input wire logic [15:0] cfg_stream_id_in,
    input wire logic [15:0] cfg_channel_id_in,
    input wire logic [47:0] time_of_year_code_in,
    input wire logic cfg_rx_blocked_in,
    input wire logic cfg_cab_fwd_in,
    input wire logic cfg_free_clk_in,
    input wire logic cfg_track_in,
    input wire logic cfg_smooth_in,
    input wire logic cfg_ext_clk_in,
    input wire logic ext_clk_in,
    input wire logic [9:0] cfg_rate_digits_in,
    input wire logic [2:0] cfg_rate_exp_in,
    input wire logic rx_bit_in,
    input wire logic rx_valid_in,
    input wire logic rx_sof_in,
    output logic tx_bit_out,
    output logic tx_valid_out,
    output logic tx_sof_out,
    output logic out_data_out,
    output logic out_clk_out
);
    if (SEC_CYC < 1 || SMOOTH_CYC < 1 || SEC_CYC >= 2**28 || SMOOTH_CYC >= 2**28)
    begin : g_chk
        $error("cbf_top: timer parameter out of range");
    end

    // ------------------------------------------------------------
    // User input on the user clock
    // ------------------------------------------------------------
    logic lr1_ff, lr2_ff, lfr_ff, lpend_ff, lfirst_ff, ltog_ff, lstart;
    logic [2:0] lcnt_ff;
    logic [6:0] lsh_ff;
    logic [7:0] lbyte_ff;

    assign lstart = user_frame_in && !lfr_ff;

    always_ff @(posedge user_clk_in)
    begin
        lr1_ff <= reset_n_in;
        lr2_ff <= lr1_ff;
    end

    // A new frame restarts byte alignment so blocked input stays aligned
    always_ff @(posedge user_clk_in)
    begin
        if (!lr2_ff)
        begin
            lfr_ff <= 1'b0;
            lcnt_ff <= 3'h0;
            lsh_ff <= 7'h00;
            lbyte_ff <= 8'h00;
            lpend_ff <= 1'b0;
            lfirst_ff <= 1'b0;
            ltog_ff <= 1'b0;
        end
        else
        begin
            lfr_ff <= user_frame_in;
            lcnt_ff <= lstart ? 3'h1 : lcnt_ff + 3'h1;
            lsh_ff <= {lsh_ff[5:0], user_data_in};
            if (lstart)
                lpend_ff <= 1'b1;
            else if (lcnt_ff == 3'h7)
            begin
                lbyte_ff <= {lsh_ff, user_data_in};
                lfirst_ff <= lpend_ff;
                lpend_ff <= 1'b0;
                ltog_ff <= !ltog_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte crossing and block assembly
    // ------------------------------------------------------------
    // Byte and first flag are held for eight user clocks, far longer
    // than the toggle takes to cross, so they are read on the strobe.
    logic [2:0] ts_ff;
    logic byte_stb, wbank_ff, wr_ok, tout, close, last;
    logic [9:0] widx_ff, wpos, nbytes;
    logic [1:0] rdy_ff;
    logic [27:0] btmr_ff;
    logic [12:0] blen_ff [0:1];
    logic [47:0] btod_ff [0:1];
    logic [7:0] txm_ff [0:1199];
    logic [10:0] waddr;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            ts_ff <= 3'h0;
        else
            ts_ff <= {ts_ff[1:0], ltog_ff};
    end

    assign byte_stb = ts_ff[1] ^ ts_ff[2];
    assign wpos = cfg_blocked_in ? (lfirst_ff ? 10'h000 : widx_ff) : widx_ff + DATA_BYTE0;
    assign wr_ok = byte_stb && cfg_chan_en_in && !rdy_ff[wbank_ff]
                   && (!cfg_blocked_in || lfirst_ff || widx_ff != 10'h000);
    assign last = wpos == (cfg_blocked_in ? BLK_LAST_BYTE : DATA_LAST_BYTE);
    assign tout = cfg_timeout_in && !cfg_blocked_in && !wr_ok && widx_ff != 10'h000
                  && !rdy_ff[wbank_ff] && btmr_ff >= 28'(SEC_CYC);
    assign close = (wr_ok && last) || tout;
    assign nbytes = wr_ok ? widx_ff + 10'h001 : widx_ff;
    assign waddr = 11'(wpos) + (wbank_ff ? 11'h258 : 11'h000);

    always_ff @(posedge core_clk_in)
    begin
        if (wr_ok)
            txm_ff[waddr] <= lbyte_ff;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            wbank_ff <= 1'b0;
            widx_ff <= 10'h000;
            btmr_ff <= 28'h0000000;
        end
        else
        begin
            btmr_ff <= (widx_ff == 10'h000) ? 28'h0000000 : btmr_ff + 28'h0000001;
            if (close)
            begin
                wbank_ff <= !wbank_ff;
                widx_ff <= 10'h000;
                blen_ff[wbank_ff] <= cfg_blocked_in ? 13'h0000 : {nbytes, 3'h0};
            end
            else if (wr_ok)
                widx_ff <= wpos + (cfg_blocked_in ? 10'h001 : 10'h001 - DATA_BYTE0);
            if (wr_ok && (cfg_blocked_in ? wpos == SYNC_END_BYTE : widx_ff == 10'h000))
                btod_ff[wbank_ff] <= time_of_year_code_in;
        end
    end

    AST_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        tout |=> (blen_ff[$past(wbank_ff)][2:0] == 3'h0) && $past(btmr_ff) >= 28'(SEC_CYC))
        else $error("timeout closed a block early or off a byte boundary");

    // ------------------------------------------------------------
    // Block transmitter with link header
    // ------------------------------------------------------------
    cbf_tx_type st_ff;
    logic [12:0] tb_ff, dpos;
    logic rbank_ff, cab_ff, raw, own, rcrc, cur, lbit;
    logic [15:0] crc_ff, seq_ff, lseq_ff;
    logic [27:0] ctmr_ff;
    logic [47:0] todv;
    logic [47:0] live_tod_ff;
    logic [111:0] hv;
    logic [79:0] lhv;
    logic [7:0] rbyte;

    always_comb
    begin
        rbyte = txm_ff[11'(tb_ff[12:3]) + (rbank_ff ? 11'h258 : 11'h000)];
        raw = rbyte[~tb_ff[2:0]];
        own = cab_ff || !cfg_blocked_in;
        hv = {SYNC_PAT, cfg_stream_id_in, seq_ff, 40'h0000000000, cab_ff ? 16'h0000 : {3'h0, blen_ff[rbank_ff]}};
        lhv = {LNK_SYNC, cfg_channel_id_in, lseq_ff, 32'h00000000};
        lbit = lhv[7'(LNK_LAST - tb_ff)];
        todv = cab_ff ? live_tod_ff : btod_ff[rbank_ff];
        dpos = tb_ff - DATA_POS;
        rcrc = own || cfg_mod_hdr_in || cfg_time_tag_in || cfg_static_time_in;
        if (tb_ff < TIME_POS)
            cur = (own || (cfg_mod_hdr_in && tb_ff >= ID_POS && tb_ff < DGRAM_POS)) ? hv[7'(HDR_TOP - tb_ff)] : raw;
        else if (tb_ff < DATA_POS)
            cur = (own || cfg_time_tag_in) ? todv[6'(TOD_TOP - tb_ff)]
                  : (cfg_static_time_in ? STATIC_TIME[6'(TOD_TOP - tb_ff)] : raw);
        else if (tb_ff < CRC_POS)
            cur = cab_ff ? CAB_PAT[~dpos[2:0]]
                  : ((!own || dpos < blen_ff[rbank_ff]) ? raw : FILL_PAT[~dpos[2:0]]);
        else
            cur = rcrc ? crc_ff[15] : raw;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            st_ff <= CBF_IDLE;
            tb_ff <= 13'h0000;
            rbank_ff <= 1'b0;
            cab_ff <= 1'b0;
            crc_ff <= CRC_INIT;
            seq_ff <= 16'h0000;
            lseq_ff <= 16'h0000;
            ctmr_ff <= 28'h0000000;
            live_tod_ff <= 48'h000000000000;
            rdy_ff <= 2'h0;
            tx_bit_out <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_sof_out <= 1'b0;
        end
        else
        begin
            tx_valid_out <= st_ff != CBF_IDLE;
            tx_sof_out <= st_ff == CBF_LINK && tb_ff == 13'h0000;
            tx_bit_out <= (st_ff == CBF_LINK) ? lbit : ((st_ff == CBF_BLK) && cur);
            if (ctmr_ff < 28'(SEC_CYC))
                ctmr_ff <= ctmr_ff + 28'h0000001;
            unique case (st_ff)
                CBF_IDLE:
                begin
                    tb_ff <= 13'h0000;
                    if (cfg_chan_en_in && (rdy_ff[rbank_ff] || ctmr_ff >= 28'(SEC_CYC)))
                    begin
                        st_ff <= CBF_LINK;
                        cab_ff <= !rdy_ff[rbank_ff];
                        live_tod_ff <= time_of_year_code_in;
                        ctmr_ff <= 28'h0000000;
                    end
                end
                CBF_LINK:
                begin
                    tb_ff <= (tb_ff == LNK_LAST) ? 13'h0000 : tb_ff + 13'h0001;
                    crc_ff <= CRC_INIT;
                    if (tb_ff == LNK_LAST)
                        st_ff <= CBF_BLK;
                end
                CBF_BLK:
                begin
                    tb_ff <= tb_ff + 13'h0001;
                    if (tb_ff < CRC_POS)
                        crc_ff <= {crc_ff[14:0], 1'b0} ^ ((crc_ff[15] ^ cur) ? CRC_POLY : 16'h0000);
                    else
                        crc_ff <= {crc_ff[14:0], 1'b0};
                    if (tb_ff == BLK_LAST)
                    begin
                        st_ff <= CBF_IDLE;
                        seq_ff <= seq_ff + 16'h0001;
                        lseq_ff <= lseq_ff + 16'h0001;
                        if (!cab_ff)
                            rbank_ff <= !rbank_ff;
                    end
                end
                default:
                    st_ff <= CBF_IDLE;
            endcase
            // Set after clear so a block closing as the other drains is kept
            if (st_ff == CBF_BLK && tb_ff == BLK_LAST && !cab_ff)
                rdy_ff[rbank_ff] <= 1'b0;
            if (close)
                rdy_ff[wbank_ff] <= 1'b1;
        end
    end

    AST_LINK_HDR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        tx_sof_out |-> ##79 (st_ff == CBF_BLK && tb_ff == 13'h0000))
        else $error("link header is not 80 bits long");

    AST_CAB_LEN: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (st_ff == CBF_BLK && cab_ff && tb_ff >= LEN_POS && tb_ff < TIME_POS) |=> !tx_bit_out)
        else $error("assurance block length field not zero");

    AST_CAB_DATA: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (st_ff == CBF_BLK && cab_ff && tb_ff >= DATA_POS && tb_ff < CRC_POS)
        |=> tx_bit_out == CAB_PAT[~$past(dpos[2:0])])
        else $error("assurance block fill pattern wrong");

    AST_PASS: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (st_ff == CBF_BLK && !own && !cfg_mod_hdr_in && !cfg_time_tag_in && !cfg_static_time_in)
        |=> tx_bit_out == $past(raw))
        else $error("unmodified block altered");

    AST_TAG: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (st_ff == CBF_BLK && !cab_ff && cfg_time_tag_in && tb_ff >= TIME_POS && tb_ff < DATA_POS)
        |=> tx_bit_out == $past(btod_ff[rbank_ff][6'(TOD_TOP - tb_ff)]))
        else $error("time field not tagged");

    // ------------------------------------------------------------
    // Block receiver into the output ring
    // ------------------------------------------------------------
    logic [12:0] rc_ff, ridx, rk;
    logic ract_ff, rdg_ff, dgo_ff, full, empty, keep, rlast;
    logic [6:0] rsh_ff;
    logic [15:0] rlen_ff;
    logic [3:0] wblk_ff, rblk_ff, occ;
    logic [12:0] slen_ff [0:7];
    logic [7:0] rxm_ff [0:4799];

    assign ridx = rx_sof_in ? 13'h0000 : rc_ff;
    assign rk = ridx - LNK_BITS;
    assign occ = wblk_ff - rblk_ff;
    assign full = occ == RING_BLKS;
    assign empty = occ == 4'h0;
    assign rlast = rx_valid_in && (rx_sof_in || ract_ff) && rk == BLK_LAST;
    assign keep = !full && (rlen_ff != 16'h0000 || (cfg_rx_blocked_in && cfg_cab_fwd_in));

    always_ff @(posedge core_clk_in)
    begin
        if (rx_valid_in && ract_ff && ridx >= LNK_BITS && rk[2:0] == 3'h7 && !full)
            rxm_ff[13'(wblk_ff[2:0]) * BLK_BYTES + 13'(rk[12:3])] <= {rsh_ff, rx_bit_in};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            rc_ff <= 13'h0000;
            ract_ff <= 1'b0;
            rsh_ff <= 7'h00;
            rlen_ff <= 16'h0000;
            rdg_ff <= 1'b0;
            wblk_ff <= 4'h0;
        end
        else if (rx_valid_in && (rx_sof_in || ract_ff))
        begin
            rc_ff <= ridx + 13'h0001;
            ract_ff <= !rlast;
            rsh_ff <= {rsh_ff[5:0], rx_bit_in};
            if (ridx >= LNK_BITS && rk >= LEN_POS && rk < TIME_POS)
                rlen_ff <= {rlen_ff[14:0], rx_bit_in};
            if (ridx >= LNK_BITS && rk == DGRAM_POS)
                rdg_ff <= rx_bit_in;
            if (rlast && keep)
            begin
                slen_ff[wblk_ff[2:0]] <= rlen_ff[12:0];
                wblk_ff <= wblk_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Smooth-mode hold-off
    // ------------------------------------------------------------
    logic run_ff, go;
    logic [27:0] stmr_ff;

    assign go = !run_ff && !empty && (!cfg_smooth_in || occ >= SMOOTH_BLKS
                || stmr_ff >= 28'(SMOOTH_CYC) || dgo_ff);

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            run_ff <= 1'b0;
            stmr_ff <= 28'h0000000;
            dgo_ff <= 1'b0;
        end
        else
        begin
            stmr_ff <= (run_ff || empty) ? 28'h0000000 : stmr_ff + 28'h0000001;
            if (go)
                run_ff <= 1'b1;
            else if (empty)
                run_ff <= 1'b0;
            // A datagram arriving as the hold-off ends is still honoured
            if (go)
                dgo_ff <= 1'b0;
            if (rlast && keep && rdg_ff)
                dgo_ff <= 1'b1;
        end
    end

    AST_SMOOTH: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ($rose(run_ff) && cfg_smooth_in)
        |-> $past(occ >= SMOOTH_BLKS || stmr_ff >= 28'(SMOOTH_CYC) || dgo_ff))
        else $error("smooth output started before five blocks or the delay");

    // ------------------------------------------------------------
    // Rate generator with tracking
    // ------------------------------------------------------------
    // The trim is about 0.122 percent, using two shifts to avoid a divider
    logic [31:0] pw, prod, rate, trim, step;
    logic [28:0] acc_ff, asum;
    logic tick;

    always_comb
    begin
        unique case (cfg_rate_exp_in)
            3'h0: pw = 32'h00000001;
            3'h1: pw = 32'h0000000A;
            3'h2: pw = 32'h00000064;
            3'h3: pw = 32'h000003E8;
            3'h4: pw = 32'h00002710;
            3'h5: pw = 32'h000186A0;
            default: pw = 32'h000F4240;
        endcase
        prod = 32'(cfg_rate_digits_in) * pw;
        rate = (prod < RATE_MIN) ? RATE_MIN : ((prod > RATE_MAX) ? RATE_MAX : prod);
        trim = (cfg_track_in && !cfg_rx_blocked_in) ? (rate >> 10) + (rate >> 12) : 32'h00000000;
        step = (occ >= 4'h4) ? rate + trim : ((occ <= 4'h1) ? rate - trim : rate);
        asum = acc_ff + 29'(step << 1);
        tick = asum >= CORE_HZ;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            acc_ff <= 29'h00000000;
        else
            acc_ff <= tick ? asum - CORE_HZ : asum;
    end

    // ------------------------------------------------------------
    // Output serializer and clock
    // ------------------------------------------------------------
    logic [2:0] es_ff;
    logic extm, fall, send, olast, obit;
    logic [12:0] ob_ff, obi;
    logic [7:0] obyte;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            es_ff <= 3'h0;
        else
            es_ff <= {es_ff[1:0], ext_clk_in};
    end

    assign extm = cfg_rx_blocked_in && cfg_ext_clk_in;
    assign send = run_ff && !empty && cfg_chan_en_in;
    assign fall = extm ? (es_ff[2] && !es_ff[1]) : (tick && out_clk_out);
    assign obi = ob_ff + (cfg_rx_blocked_in ? 13'h0000 : DATA_POS);
    assign olast = ob_ff == (cfg_rx_blocked_in ? BLK_LAST : slen_ff[rblk_ff[2:0]] - 13'h0001);
    assign obyte = rxm_ff[13'(rblk_ff[2:0]) * BLK_BYTES + 13'(obi[12:3])];
    assign obit = obyte[~obi[2:0]];

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            ob_ff <= 13'h0000;
            rblk_ff <= 4'h0;
            out_data_out <= 1'b1;
            out_clk_out <= 1'b1;
        end
        else
        begin
            if (fall && send)
            begin
                out_data_out <= obit;
                ob_ff <= olast ? 13'h0000 : ob_ff + 13'h0001;
                if (olast)
                    rblk_ff <= rblk_ff + 4'h1;
            end
            else if (fall || !cfg_chan_en_in)
                out_data_out <= 1'b1;
            if (extm)
                out_clk_out <= es_ff[2];
            else if (!cfg_chan_en_in)
                out_clk_out <= 1'b1;
            else if (tick && !out_clk_out)
                out_clk_out <= 1'b1;
            else if (tick && (send || cfg_free_clk_in))
                out_clk_out <= 1'b0;
        end
    end

    AST_CLAMP: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!extm && !cfg_free_clk_in && !send && out_clk_out) |=> out_clk_out)
        else $error("clamped clock left high level while idle");

endmodule // cbf_top

// ---- rtl/cbf_pkg.sv ----
// Constants, block layout and types for the channel block framer.
// Assumes bit 0 of every block is the first bit on the wire, MSB first.
package cbf_pkg;
    // Block layout, bit positions within the 4800-bit block
    localparam logic [12:0] BLK_LAST = 13'h12BF;
    localparam logic [12:0] LNK_LAST = 13'h004F;
    localparam logic [12:0] LNK_BITS = 13'h0050;
    localparam logic [12:0] ID_POS = 13'h0018;
    localparam logic [12:0] DGRAM_POS = 13'h0038;
    localparam logic [12:0] LEN_POS = 13'h0060;
    localparam logic [12:0] TIME_POS = 13'h0070;
    localparam logic [12:0] DATA_POS = 13'h00A0;
    localparam logic [12:0] CRC_POS = 13'h12B0;
    localparam logic [12:0] HDR_TOP = 13'h006F;
    localparam logic [12:0] TOD_TOP = 13'h009F;
    localparam logic [12:0] BLK_BYTES = 13'h0258;
    // Byte positions for assembly
    localparam logic [9:0] DATA_BYTE0 = 10'h014;
    localparam logic [9:0] SYNC_END_BYTE = 10'h002;
    localparam logic [9:0] BLK_LAST_BYTE = 10'h257;
    localparam logic [9:0] DATA_LAST_BYTE = 10'h255;
    // Fixed patterns
    localparam logic [23:0] SYNC_PAT = 24'hF8A2C5;
    localparam logic [15:0] LNK_SYNC = 16'hE4B7;
    localparam logic [7:0] CAB_PAT = 8'hC9;
    localparam logic [7:0] FILL_PAT = 8'h55;
    localparam logic [47:0] STATIC_TIME = 48'h000000000000;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // Timing
    localparam int CORE_KHZ = 250000;
    localparam logic [28:0] CORE_HZ = 29'(CORE_KHZ * 1000);
    localparam int ONE_SEC_MS = 1000;
    localparam int SMOOTH_MS = 264;
    localparam int ONE_SEC_CYC = CORE_KHZ * ONE_SEC_MS;
    localparam int SMOOTH_DLY_CYC = CORE_KHZ * SMOOTH_MS;
    localparam logic [3:0] SMOOTH_BLKS = 4'h5;
    localparam logic [31:0] RATE_MIN = 32'h0000000A;
    localparam logic [31:0] RATE_MAX = 32'h006ACFC0;
    // Receive ring depth in blocks
    localparam logic [3:0] RING_BLKS = 4'h8;

    typedef enum logic [1:0]
    {
        CBF_IDLE = 2'b00,
        CBF_LINK = 2'b01,
        CBF_BLK = 2'b10
    } cbf_tx_type;
endpackage

// ---- testbench/cbf_user_model.sv ----
// User-side serial source for the block framer bench.
// Assumes the bench calls send_bits; the clock stands still between calls.
`timescale 1ns/1ns
module cbf_user_model
(
    output logic user_clk_out,
    output logic user_data_out,
    output logic user_frame_out
);
    // Unblocked sender only: a whole framed block takes far longer than the run allows
    initial
    begin
        user_clk_out = 1'b0;
        user_data_out = 1'b0;
        user_frame_out = 1'b0;
    end
    // Sends the n top bits of b, MSB first; data moves 1 ns after the falling edge
    // so that back-to-back calls never drive the data line twice in one step
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            #1 user_data_out = b[i];
            #61 user_clk_out = 1'b1;
            #63 user_clk_out = 1'b0;
        end
        #1 user_data_out = ~user_data_out;
    endtask
endmodule // cbf_user_model

// ---- testbench/tb_top.sv ----
// Bench for the channel block framer, link looped back onto itself.
// Assumes the user model feeds the user_clk_in input domain.
`timescale 1ns/1ns
module tb_top;
    import cbf_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] cfg = 12'h021;
    logic t_bit, t_val, t_sof, o_dat, o_clk, u_clk, u_dat, u_frm;
    logic xclk = 1'b0;
    logic [15:0] sid = 16'hA5C3;
    logic [15:0] cid = 16'h3C5A;
    logic [47:0] tod = 48'h0123456789AB;
    logic [0:4879] cap;
    int n_errors = 0;
    int cmp_count = 0;
    always #2 clk = ~clk;
    cbf_user_model u_cbf_user_model (.user_clk_out(u_clk), .user_data_out(u_dat), .user_frame_out(u_frm));
    cbf_top #(.SEC_CYC(8000), .SMOOTH_CYC(500)) u_cbf_top
    (
        .core_clk_in(clk), .reset_n_in(rst_n), .user_clk_in(u_clk), .user_data_in(u_dat),
        .user_frame_in(u_frm), .cfg_chan_en_in(cfg[0]), .cfg_blocked_in(cfg[1]), .cfg_mod_hdr_in(cfg[2]),
        .cfg_time_tag_in(cfg[3]), .cfg_static_time_in(cfg[4]), .cfg_timeout_in(cfg[5]),
        .cfg_stream_id_in(sid), .cfg_channel_id_in(cid), .time_of_year_code_in(tod),
        .cfg_rx_blocked_in(cfg[6]), .cfg_cab_fwd_in(cfg[7]), .cfg_free_clk_in(cfg[8]), .cfg_track_in(cfg[9]),
        .cfg_smooth_in(cfg[10]), .cfg_ext_clk_in(cfg[11]), .ext_clk_in(xclk), .cfg_rate_digits_in(10'h2BC),
        .cfg_rate_exp_in(3'h4), .rx_bit_in(t_bit), .rx_valid_in(t_val), .rx_sof_in(t_sof),
        .tx_bit_out(t_bit), .tx_valid_out(t_val), .tx_sof_out(t_sof), .out_data_out(o_dat), .out_clk_out(o_clk)
    );
    task automatic final_report();
        $display("n_errors %0d cmp_count %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Waits for a link block and records all of it
    task automatic grab();
        int n = 0;
        int v = 0;
        for (n = 0; n < 40000 && t_sof !== 1'b1; n++)
            @(negedge clk);
        if (n == 40000)
        begin
            n_errors++;
            final_report();
        end
        for (int i = 0; i < 4880; i++)
        begin
            cap[i] = t_bit;
            v += int'(t_val === 1'b1);
            @(negedge clk);
        end
        chk(v, 4880);
        chk(t_val, 1'b0);
    endtask
    // Idle source: assurance block with link header
    task automatic t_cab();
        grab();
        chk(cap[0:15], LNK_SYNC);
        chk(cap[16:31], 16'h3C5A);
        chk(cap[80:103], SYNC_PAT);
        chk(cap[176:191], 16'h0000);
        chk(cap[240:255], {2{CAB_PAT}});
        chk(o_clk, 1'b1);
    endtask
    // Three bytes and a loose nibble, closed by the timeout
    task automatic t_timeout();
        u_cbf_user_model.send_bits(8'hC3, 8);
        u_cbf_user_model.send_bits(8'h5A, 8);
        u_cbf_user_model.send_bits(8'h96, 8);
        u_cbf_user_model.send_bits(8'hF0, 4);
        for (int k = 0; k < 4 && cap[176:191] === 16'h0000; k++)
            grab();
        chk(cap[176:191], 16'h0018);
        chk(cap[104:119], 16'hA5C3);
        chk(cap[240:263], 24'hC35A96);
        chk(cap[264:279], {2{FILL_PAT}});
    endtask
    // Unblocked output carries only the data bits, then clamps
    task automatic t_out();
        logic [23:0] d = 24'h0;
        logic p = 1'b1;
        int b = 0;
        int h = 0;
        for (int n = 0; n < 60000 && b < 24; n++)
        begin
            @(negedge clk);
            if (o_clk === 1'b1 && p === 1'b0)
            begin
                d = {d[22:0], o_dat};
                b++;
            end
            p = o_clk;
        end
        chk(b, 24);
        if (b < 24)
            final_report();
        chk(d, 24'hC35A96);
        repeat (300) @(negedge clk) h += int'(o_clk !== 1'b1);
        chk(h, 0);
        @(posedge clk) cfg[8] <= 1'b1;
        h = 0;
        repeat (300)
        begin
            @(negedge clk);
            h += int'(o_clk !== p);
            p = o_clk;
        end
        chk(h >= 15, 1'b1);
    endtask
    // Smooth mode holds a lone short block back for the hold-off time
    task automatic t_smooth();
        int n = 0;
        @(posedge clk) cfg <= cfg ^ 12'h500;
        u_cbf_user_model.send_bits(8'hA5, 4);
        cap[176:191] = 16'h0000;
        for (int k = 0; k < 4 && cap[176:191] === 16'h0000; k++)
            grab();
        chk(cap[176:191], 16'h0008);
        for (n = 0; n < 2000 && o_clk !== 1'b0; n++)
            @(negedge clk);
        chk(n >= 500 && n < 540, 1'b1);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        u_cbf_user_model.send_bits(8'h00, 3);
        @(posedge clk) rst_n <= 1'b1;
        @(negedge clk) chk({t_val, o_clk, o_dat}, 3'b011);
        u_cbf_user_model.send_bits(8'h00, 2);
        t_cab();
        t_timeout();
        t_out();
        t_smooth();
        final_report();
    end
endmodule // tb_top
